// file: design/ots_defs.vh
`ifndef OTS_DEFS_VH
`define OTS_DEFS_VH

// ----------------------------------------
// Store geometry
// ----------------------------------------
`define OTS_SECTORS      4
`define OTS_ROWS         512
`define OTS_ROW_BITS     32
`define OTS_IDX_BITS     11

// ----------------------------------------
// Programming port resource numbers
// ----------------------------------------
`define OTS_RID_ADDR     24'h100200
`define OTS_RID_DATA     24'h200100
`define OTS_RID_CTRL     24'h100300

// Address that selects the security word
`define OTS_SEC_ADDR     16'hFFFF

// Control port command bits
`define OTS_CTRL_PROG    0
`define OTS_CTRL_READ    1

// ----------------------------------------
// Security configuration bit positions
// ----------------------------------------
`define OTS_SB_JTAG_DIS  0
`define OTS_SB_LINK_DIS  1
`define OTS_SB_SEC_BOOT  5
`define OTS_SB_REDUND    7
`define OTS_SB_LOCK_LO   8
`define OTS_SB_MASTER    12
`define OTS_SB_TP_OTP    13
`define OTS_SB_DBG_DIS   14
`define OTS_SB_GP_HI     21
`define OTS_SB_GP_LO     15
`define OTS_SB_UID_HI    31
`define OTS_SB_UID_LO    22

// ----------------------------------------
// Test-port commands
// ----------------------------------------
`define OTS_TP_TEST_PORT_DEVICE_IDENT    3'h1
`define OTS_TP_USERCODE  3'h2
`define OTS_TP_OTP_RD    3'h3
`define OTS_TP_OTP_WR    3'h4
`define OTS_TP_STATE     3'h5

// Number of TAPs in the chain after reset
`define OTS_TAP_COUNT    2'h2

`endif

// file: design/ots_sync.v
`timescale 1ns/1ps
`include "ots_defs.vh"

// Three-stage pin synchroniser; output follows once stages two and three agree
module ots_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         nrst,
  // Pin side
  input  wire [W-1:0] pinIn,
  // Core side
  output wire [W-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg val_q;
      // Shift chain and agreement filter
      always @(posedge core_clk) begin
        if (!nrst) begin
          s1_q  <= 1'b1;
          s2_q  <= 1'b1;
          s3_q  <= 1'b1;
          val_q <= 1'b1;
        end else begin
          s1_q <= pinIn[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            val_q <= s3_q;
          end
        end
      end
      assign syncOut[i] = val_q;
    end
  endgenerate

endmodule

// file: design/ots_top.v
`timescale 1ns/1ps
`include "ots_defs.vh"

// Operation
// - Store is four sectors of 512 rows, 32 bits each, 8 KB total.
// - Security word loads from the store at power up before taking effect.
// - Remaining store contents are copied out to SRAM for first execution.
// - Address port is 16 bits wide at resource 0x100200.
// - Data port is 32 bits wide at resource 0x200100.
// - Control port is 16 bits wide at resource 0x100300.
// - Bit 0 disables all test-port access to tile state and memory.
// - Bit 1 refuses other tiles' switch access to processor state.
// - Bit 5 forces boot from store address 0, bypassing boot ROM.
// - Bit 7 enables redundant rows in the store.
// - Bits 8 to 11 each lock programming of sectors 0 to 3.
// - Bit 12 blocks all programming, including the security word.
// - Bit 13 blocks test-port reads and writes of the store.
// - Bit 14 disables the debug synchronisation pin.
// - Bits 21 to 15 are a general field readable by software.
// - Bits 31 to 22 extend the user code returned by the test port.
// - After reset two TAPs sit in the chain: boundary scan and chip.
// - Output mode: pin floats until a breakpoint, then is driven low.
// - Input mode: pin driven low externally puts tile into debug.
// - Identity word holds version, part, maker fields, bit 0 is 1.
// - User code takes bits 22 to 31 of the security word.
module ots_top #(
  parameter SECTORS  = `OTS_SECTORS,
  parameter ROWS     = `OTS_ROWS,
  parameter ID_VER   = 4'h1,      // Arbitrary value
  parameter ID_PART  = 16'h0ABC,  // Arbitrary value
  parameter ID_MAKER = 11'h155,   // Arbitrary value
  parameter SI_REV   = 16'h0042   // Arbitrary value
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // Processor I/O port access
  input  wire        portWr,
  input  wire        portRd,
  input  wire [23:0] portId,
  input  wire [31:0] portWrData,
  output reg  [31:0] portRdData_q,
  output reg         portRdValid_q,
  output reg         progDone_q,
  output reg         progRefused_q,
  // Boot sequence
  output reg         secLoaded_q,
  output reg         copyValid_q,
  output reg  [10:0] copyAddr_q,
  output reg  [31:0] copyData_q,
  output reg         bootGo_q,
  output reg         bootFromOtp_q,
  output reg         redundRowsEn_q,
  output reg  [6:0]  swGpField_q,
  // Test-port side
  input  wire        tpRst_n_pin,
  input  wire        tpCmdValid,
  input  wire [2:0]  tpCmd,
  input  wire [15:0] tpAddr,
  input  wire [31:0] tpWrData,
  output reg  [31:0] tpRdData_q,
  output reg         tpRdValid_q,
  output reg         tpDenied_q,
  output reg         tpStateReq_q,
  output reg         bsTapPresent_q,
  output reg         chipTapPresent_q,
  // Switch access from other tiles
  input  wire        linkReq,
  output reg         linkGrant_q,
  output reg         linkDenied_q,
  // Debug synchronisation pin
  input  wire        dbgDirOut,
  input  wire        dbgBreak,
  input  wire        dbgResume,
  input  wire        dbgPinIn,
  output reg         dbgPinOut_q,
  output reg         dbgPinOe_q,
  output reg         dbgEnter_q
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  localparam NROWS  = SECTORS * ROWS;
  localparam ST_LOAD = 3'b001;
  localparam ST_COPY = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [31:0] mem [0:NROWS-1];
  reg  [31:0] secStore;
  reg  [31:0] secCfg_q;
  wire [31:0] cfgNow;
  reg  [2:0]  state_q;
  reg  [15:0] addr_q;
  reg  [31:0] data_q;
  reg  [31:0] rdWord_q;
  reg         dbgPinPrev_q;
  wire [1:0]  syncPins;
  wire        tpRstSync_n;
  wire        dbgSync;
  integer     k;

  // Unprogrammed store reads as zero
  initial begin
    for (k = 0; k < NROWS; k = k + 1) begin
      mem[k] = 32'h0000_0000;
    end
    secStore = 32'h0000_0000;
  end

  // Pin synchronisers
  ots_sync #(
    .W (2)
  ) uSync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pinIn    ({tpRst_n_pin, dbgPinIn}),
    .syncOut  (syncPins)
  );
  assign tpRstSync_n = syncPins[1];
  assign dbgSync     = syncPins[0];

  // ----------------------------------------
  // Programming request decode
  // ----------------------------------------
  reg        cpuProg;
  reg        cpuRead;
  reg        tpOtpOk;
  reg        tpProg;
  reg        doProg;
  reg [15:0] pAddr;
  reg [31:0] pData;
  reg        inRange;
  reg        isSec;
  reg [1:0]  pSector;
  reg        locked;

  // Source select: processor wins over test port
  always @* begin
    cpuProg = portWr && (portId == `OTS_RID_CTRL)
              && portWrData[`OTS_CTRL_PROG];
    cpuRead = portWr && (portId == `OTS_RID_CTRL)
              && portWrData[`OTS_CTRL_READ];
    tpOtpOk = tpRstSync_n && secLoaded_q
              && !secCfg_q[`OTS_SB_JTAG_DIS]
              && !secCfg_q[`OTS_SB_TP_OTP];
    tpProg  = tpCmdValid && (tpCmd == `OTS_TP_OTP_WR) && tpOtpOk && !cpuProg;
    doProg  = (cpuProg || tpProg) && (state_q == ST_RUN);
    pAddr   = cpuProg ? addr_q : tpAddr;
    pData   = cpuProg ? data_q : tpWrData;
    isSec   = (pAddr == `OTS_SEC_ADDR);
    inRange = (pAddr < NROWS);
    pSector = pAddr[10:9];
    // Master lock covers everything, sector locks their own rows
    locked  = secCfg_q[`OTS_SB_MASTER]
              || (!isSec && secCfg_q[`OTS_SB_LOCK_LO + pSector])
              || (!isSec && !inRange);
  end

  // ----------------------------------------
  // Store write: bits only ever set
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (doProg && !locked) begin
      if (isSec) begin
        secStore <= secStore | pData;
      end else begin
        mem[pAddr[10:0]] <= mem[pAddr[10:0]] | pData;
      end
    end
  end

  // Programming outcome pulses
  always @(posedge core_clk) begin
    if (!nrst) begin
      progDone_q    <= 1'b0;
      progRefused_q <= 1'b0;
    end else begin
      progDone_q    <= doProg && !locked;
      progRefused_q <= doProg && locked;
    end
  end

  // ----------------------------------------
  // Processor I/O ports
  // ----------------------------------------
  // Port writes latch address and data, control triggers reads
  always @(posedge core_clk) begin
    if (!nrst) begin
      addr_q   <= 16'h0000;
      data_q   <= 32'h0000_0000;
      rdWord_q <= 32'h0000_0000;
    end else begin
      if (portWr && (portId == `OTS_RID_ADDR)) begin
        addr_q <= portWrData[15:0];
      end
      if (portWr && (portId == `OTS_RID_DATA)) begin
        data_q <= portWrData;
      end
      if (cpuRead && (state_q == ST_RUN)) begin
        if (addr_q == `OTS_SEC_ADDR) begin
          rdWord_q <= secStore;
        end else if (addr_q < NROWS) begin
          rdWord_q <= mem[addr_q[10:0]];
        end else begin
          rdWord_q <= 32'h0000_0000;
        end
      end
    end
  end

  // Port reads; unmapped ids return zero
  always @(posedge core_clk) begin
    if (!nrst) begin
      portRdData_q  <= 32'h0000_0000;
      portRdValid_q <= 1'b0;
    end else begin
      portRdValid_q <= portRd;
      if (portRd) begin
        case (portId)
          `OTS_RID_ADDR: portRdData_q <= {16'h0000, addr_q};
          `OTS_RID_DATA: portRdData_q <= rdWord_q;
          `OTS_RID_CTRL: portRdData_q <= {29'h0, state_q == ST_RUN,
                                          progRefused_q, progDone_q};
          default:       portRdData_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Boot: load security word, copy store out
  // ----------------------------------------
  // Config outputs take the word on the same edge that loads it
  assign cfgNow = (state_q == ST_LOAD) ? secStore : secCfg_q;

  always @(posedge core_clk) begin
    if (!nrst) begin
      state_q        <= ST_LOAD;
      secCfg_q       <= 32'h0000_0000;
      secLoaded_q    <= 1'b0;
      copyValid_q    <= 1'b0;
      copyAddr_q     <= 11'h000;
      copyData_q     <= 32'h0000_0000;
      bootGo_q       <= 1'b0;
      bootFromOtp_q  <= 1'b0;
      redundRowsEn_q <= 1'b0;
      swGpField_q    <= 7'h00;
    end else begin
      bootGo_q <= 1'b0;
      case (state_q)
        ST_LOAD: begin
          secCfg_q    <= secStore;
          secLoaded_q <= 1'b1;
          copyAddr_q  <= 11'h000;
          state_q     <= ST_COPY;
        end
        ST_COPY: begin
          copyValid_q <= 1'b1;
          copyData_q  <= mem[copyAddr_q];
          if (copyValid_q) begin
            if (copyAddr_q == NROWS - 1) begin
              copyValid_q <= 1'b0;
              bootGo_q    <= 1'b1;
              state_q     <= ST_RUN;
            end else begin
              copyAddr_q <= copyAddr_q + 11'h001;
              copyData_q <= mem[copyAddr_q + 11'h001];
            end
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
      // Configuration outputs follow the loaded word
      bootFromOtp_q  <= cfgNow[`OTS_SB_SEC_BOOT];
      redundRowsEn_q <= cfgNow[`OTS_SB_REDUND];
      swGpField_q    <= cfgNow[`OTS_SB_GP_HI:`OTS_SB_GP_LO];
    end
  end

  // ----------------------------------------
  // Test-port command service
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      tpRdData_q       <= 32'h0000_0000;
      tpRdValid_q      <= 1'b0;
      tpDenied_q       <= 1'b0;
      tpStateReq_q     <= 1'b0;
      bsTapPresent_q   <= 1'b1;
      chipTapPresent_q <= 1'b1;
    end else begin
      tpRdValid_q  <= 1'b0;
      tpDenied_q   <= 1'b0;
      tpStateReq_q <= 1'b0;
      // Test-port reset held low keeps the port idle
      if (tpCmdValid && tpRstSync_n) begin
        case (tpCmd)
          `OTS_TP_TEST_PORT_DEVICE_IDENT: begin
            tpRdValid_q <= 1'b1;
            tpRdData_q  <= {ID_VER, ID_PART, ID_MAKER, 1'b1};
          end
          `OTS_TP_USERCODE: begin
            tpRdValid_q <= 1'b1;
            tpRdData_q  <= {secCfg_q[`OTS_SB_UID_HI:`OTS_SB_UID_LO],
                            6'h00, SI_REV};
          end
          `OTS_TP_OTP_RD: begin
            if (tpOtpOk && (state_q == ST_RUN)) begin
              tpRdValid_q <= 1'b1;
              if (tpAddr == `OTS_SEC_ADDR) begin
                tpRdData_q <= secStore;
              end else if (tpAddr < NROWS) begin
                tpRdData_q <= mem[tpAddr[10:0]];
              end else begin
                tpRdData_q <= 32'h0000_0000;
              end
            end else begin
              tpDenied_q <= 1'b1;
            end
          end
          `OTS_TP_OTP_WR: begin
            tpDenied_q <= !tpOtpOk;
          end
          `OTS_TP_STATE: begin
            if (secLoaded_q && !secCfg_q[`OTS_SB_JTAG_DIS]) begin
              tpStateReq_q <= 1'b1;
            end else begin
              tpDenied_q <= 1'b1;
            end
          end
          default: begin
            tpDenied_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Switch access from other tiles
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      linkGrant_q  <= 1'b0;
      linkDenied_q <= 1'b0;
    end else begin
      linkGrant_q  <= linkReq && secLoaded_q && !secCfg_q[`OTS_SB_LINK_DIS];
      linkDenied_q <= linkReq && !(secLoaded_q
                      && !secCfg_q[`OTS_SB_LINK_DIS]);
    end
  end

  // ----------------------------------------
  // Debug synchronisation pin
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      dbgPinOut_q  <= 1'b0;
      dbgPinOe_q   <= 1'b0;
      dbgEnter_q   <= 1'b0;
      dbgPinPrev_q <= 1'b1;
    end else begin
      dbgPinOut_q  <= 1'b0;
      dbgPinPrev_q <= dbgSync;
      dbgEnter_q   <= 1'b0;
      if (!secLoaded_q || secCfg_q[`OTS_SB_DBG_DIS]) begin
        dbgPinOe_q <= 1'b0;
      end else if (dbgDirOut) begin
        // Float until breakpoint, then pull low until resume
        if (dbgBreak) begin
          dbgPinOe_q <= 1'b1;
        end else if (dbgResume) begin
          dbgPinOe_q <= 1'b0;
        end
      end else begin
        dbgPinOe_q <= 1'b0;
        dbgEnter_q <= dbgPinPrev_q && !dbgSync;
      end
    end
  end

endmodule

// file: dv/ots_host.sv
`timescale 1ns/1ps

// ----------------------------------------
// Far side: sync pin wire and test-port reset
// ----------------------------------------
module ots_host (
  // Device drive of the sync pin
  input  wire dbgPinOut_q,
  input  wire dbgPinOe_q,
  // External party pulls the pin low
  input  wire pullLow,
  // Pin levels
  output wire pinLevel,
  output reg  tpRst_n
);
  // Pull-up wins when nobody drives
  assign pinLevel = (dbgPinOe_q ? dbgPinOut_q : 1'b1) & ~pullLow;

  // Test-port reset held low through power up
  initial begin
    tpRst_n = 1'b0;
    #200 tpRst_n = 1'b1;
  end
endmodule

// file: dv/ots_props.sv
`timescale 1ns/1ps
`include "ots_defs.vh"

// ----------------------------------------
// Port-level checks of the store block
// ----------------------------------------
module ots_props (
  // Clock and reset
  input wire        core_clk,
  input wire        nrst,
  // Processor ports
  input wire        portWr,
  input wire        portRd,
  input wire [23:0] portId,
  input wire [31:0] portWrData,
  input wire        portRdValid_q,
  input wire        progDone_q,
  input wire        progRefused_q,
  // Boot
  input wire        secLoaded_q,
  input wire        copyValid_q,
  input wire [10:0] copyAddr_q,
  input wire        bootGo_q,
  input wire        bootFromOtp_q,
  input wire [6:0]  swGpField_q,
  // Test port and switch
  input wire        tpCmdValid,
  input wire [2:0]  tpCmd,
  input wire [31:0] tpRdData_q,
  input wire        tpRdValid_q,
  input wire        bsTapPresent_q,
  input wire        chipTapPresent_q,
  input wire        linkReq,
  input wire        linkGrant_q,
  input wire        linkDenied_q,
  // Debug pin
  input wire        dbgDirOut,
  input wire        dbgResume,
  input wire        dbgPinOut_q,
  input wire        dbgPinOe_q,
  input wire        dbgEnter_q
);
  reg progReq_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Programming request seen one edge earlier
  always @(posedge core_clk) begin
    progReq_q <= (portWr && portId == `OTS_RID_CTRL && portWrData[`OTS_CTRL_PROG])
                 || (tpCmdValid && tpCmd == `OTS_TP_OTP_WR);
  end

  AST_TAPS: assert property (bsTapPresent_q && chipTapPresent_q)
    else $error("tap missing from chain");
  AST_LOAD: assert property ($rose(nrst) |-> ##[1:2] secLoaded_q)
    else $error("security word not loaded");
  AST_COPY_AFTER_LOAD: assert property (copyValid_q |-> secLoaded_q)
    else $error("copy before load");
  AST_COPY_STEP: assert property (copyValid_q && copyAddr_q != 11'h7FF |=>
    copyValid_q && copyAddr_q == $past(copyAddr_q) + 11'h001) else $error("copy gap");
  AST_CFG_HOLD: assert property (secLoaded_q && $past(secLoaded_q) |->
    $stable(swGpField_q) && $stable(bootFromOtp_q)) else $error("config moved");
  AST_PROG_CAUSE: assert property (progDone_q || progRefused_q |->
    progReq_q && !(progDone_q && progRefused_q)) else $error("bad program answer");
  AST_RD_ANSWER: assert property (portRd && portId == `OTS_RID_DATA |=> portRdValid_q)
    else $error("read not answered");
  AST_TP_ID: assert property (tpCmdValid && tpCmd == `OTS_TP_TEST_PORT_DEVICE_IDENT && secLoaded_q |=>
    tpRdValid_q && tpRdData_q[0]) else $error("identity word bad");
  AST_LINK: assert property (linkReq |=> linkGrant_q != linkDenied_q)
    else $error("link answer bad");
  AST_DBG_LOW: assert property (dbgPinOe_q |-> !dbgPinOut_q)
    else $error("sync pin driven high");
  AST_DBG_HOLD: assert property (dbgPinOe_q && dbgDirOut && !dbgResume |=> dbgPinOe_q)
    else $error("sync pin released early");
  AST_DBG_FLOAT: assert property (!dbgDirOut |=> !dbgPinOe_q)
    else $error("sync pin driven in input mode");

  // Main scenarios reached
  cover property (bootGo_q);
  cover property (progRefused_q);
  cover property (dbgEnter_q);
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "ots_defs.vh"

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam [3:0]  VER   = 4'h3;     // Arbitrary value
  localparam [15:0] PART  = 16'h1234; // Arbitrary value
  localparam [10:0] MAKER = 11'h2B1;  // Arbitrary value
  localparam [15:0] REV   = 16'h0101; // Arbitrary value
  localparam [31:0] SEC1  = {10'h2A5, 7'h55, 7'h61, 8'hA2};
  reg         core_clk, nrst, portWr, portRd, tpCmdValid, linkReq;
  reg         dbgDirOut, dbgBreak, dbgResume, pullLow;
  reg  [23:0] portId;
  reg  [31:0] portWrData, tpWrData, rs, d0;
  reg  [15:0] tpAddr, a0;
  reg  [2:0]  tpCmd;
  reg  [35:0] expQ[$];
  integer     bad_count, n_tests, i;
  wire [31:0] portRdData_q, tpRdData_q, copyData_q;
  wire [10:0] copyAddr_q;
  wire [6:0]  swGpField_q;
  wire        tpRst_n, pinLevel, portRdValid_q, progDone_q, progRefused_q, secLoaded_q;
  wire        bootGo_q, bootFromOtp_q, redundRowsEn_q, tpRdValid_q, tpDenied_q;
  wire        tpStateReq_q, bsTapPresent_q, chipTapPresent_q, linkGrant_q, linkDenied_q;
  wire        dbgPinOut_q, dbgPinOe_q, dbgEnter_q, copyValid_q;

  ots_top #(.ID_VER(VER), .ID_PART(PART), .ID_MAKER(MAKER), .SI_REV(REV)) u_ots_top (
    .tpRst_n_pin(tpRst_n),
    .dbgPinIn   (pinLevel),
    .*
  );
  ots_host u_ots_host (.dbgPinOut_q(dbgPinOut_q), .dbgPinOe_q(dbgPinOe_q),
    .pullLow(pullLow), .pinLevel(pinLevel), .tpRst_n(tpRst_n));

  // ----------------------------------------
  // Clock, helpers and checking
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction

  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask

  task cmp(input [35:0] e, input [35:0] a);
    begin
      n_tests = n_tests + 1;
      if (a !== e) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: expected %h got %h", $time, e, a);
      end
    end
  endtask

  task lvl(input [31:0] a, input [31:0] e);
    cmp({4'hA, e}, {4'hA, a});
  endtask

  task note(input [3:0] k, input [31:0] d);
    expQ.push_back({k, d});
  endtask

  task pop(input [3:0] k, input [31:0] a);
    if (expQ.size() == 0) cmp(36'hFFFFFFFFF, {k, a});
    else cmp(expQ.pop_front(), {k, a});
  endtask

  // Each result against the oldest note
  always @(posedge core_clk) begin
    if (portRdValid_q) pop(4'h0, portRdData_q);
    if (tpRdValid_q) pop(4'h1, tpRdData_q);
    if (tpDenied_q) pop(4'h2, 32'h0);
    if (progDone_q) pop(4'h3, 32'h0);
    if (progRefused_q) pop(4'h4, 32'h0);
    if (tpStateReq_q) pop(4'h5, 32'h0);
    if (linkGrant_q) pop(4'h6, 32'h0);
    if (linkDenied_q) pop(4'h7, 32'h0);
    if (dbgEnter_q) pop(4'h8, 32'h0);
    if (copyValid_q && copyAddr_q == 11'h7FF) pop(4'h9, copyData_q);
  end

  task prog(input [15:0] a, input [31:0] d, input [3:0] k);
    begin
      note(k, 32'h0);
      portWr <= 1'b1;
      portId <= `OTS_RID_ADDR;
      portWrData <= {16'h0, a};
      tick(1);
      portId <= `OTS_RID_DATA;
      portWrData <= d;
      tick(1);
      portId <= `OTS_RID_CTRL;
      portWrData <= 32'h1;
      tick(1);
      portWr <= 1'b0;
      tick(2);
    end
  endtask

  task prd(input [23:0] id, input [31:0] e);
    begin
      note(4'h0, e);
      portRd <= 1'b1;
      portId <= id;
      tick(1);
      portRd <= 1'b0;
      tick(2);
    end
  endtask

  task rd(input [15:0] a, input [31:0] e);
    begin
      portWr <= 1'b1;
      portId <= `OTS_RID_ADDR;
      portWrData <= {16'h0, a};
      tick(1);
      portId <= `OTS_RID_CTRL;
      portWrData <= 32'h2;
      tick(1);
      portWr <= 1'b0;
      prd(`OTS_RID_DATA, e);
    end
  endtask

  task tp(input [2:0] c, input [15:0] a, input [31:0] d, input [3:0] k, input [31:0] e);
    begin
      if (k != 4'hF) note(k, e);
      tpCmdValid <= 1'b1;
      tpCmd <= c;
      tpAddr <= a;
      tpWrData <= d;
      tick(1);
      tpCmdValid <= 1'b0;
      tick(2);
    end
  endtask

  task link(input [3:0] k);
    begin
      note(k, 32'h0);
      linkReq <= 1'b1;
      tick(1);
      linkReq <= 1'b0;
      tick(2);
    end
  endtask

  task brk;
    begin
      dbgDirOut <= 1'b1;
      tick(2);
      lvl({dbgPinOe_q, pinLevel}, 32'h1);
      dbgBreak <= 1'b1;
      tick(1);
      dbgBreak <= 1'b0;
      tick(4);
    end
  endtask

  task pinPull;
    begin
      dbgDirOut <= 1'b0;
      pullLow <= 1'b1;
      tick(8);
      pullLow <= 1'b0;
      tick(8);
    end
  endtask

  task boot;
    begin
      note(4'h9, d0);
      nrst <= 1'b0;
      tick(8);
      nrst <= 1'b1;
      for (i = 0; i < 3000 && bootGo_q !== 1'b1; i = i + 1) tick(1);
      lvl({31'h0, bootGo_q}, 32'h1);
      tick(2);
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Hang guard
  initial begin
    tick(20000);
    bad_count = bad_count + 1;
    summarize;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {portWr, portRd, tpCmdValid, linkReq, dbgDirOut, dbgBreak, dbgResume, pullLow} = 8'h0;
    portId = 24'h0;
    portWrData = 32'h0;
    tpWrData = 32'h0;
    tpAddr = 16'h0;
    tpCmd = 3'h0;
    bad_count = 0;
    n_tests = 0;
    rs = 32'hAEC0;
    d0 = 32'h0;
    boot;
    lvl({bsTapPresent_q, chipTapPresent_q, bootFromOtp_q, redundRowsEn_q, 21'h0, swGpField_q},
      32'hC0000000);
    tp(`OTS_TP_TEST_PORT_DEVICE_IDENT, 16'h0, 32'h0, 4'h1, {VER, PART, MAKER, 1'b1});
    tp(`OTS_TP_USERCODE, 16'h0, 32'h0, 4'h1, {16'h0, REV});
    link(4'h6);
    for (i = 0; i < 4; i = i + 1) begin
      rs = xs(rs);
      a0 = {5'h0, i[1:0], 1'b0, rs[7:0]};
      prog(a0, rs, 4'h3);
      rd(a0, rs);
    end
    prd(`OTS_RID_ADDR, {16'h0, a0});
    prd(`OTS_RID_CTRL, 32'h4);
    prd(24'h0, 32'h0);
    prog(16'h0800, 32'h1, 4'h4);
    rs = xs(rs);
    d0 = rs;
    tp(`OTS_TP_OTP_WR, 16'h07FF, rs, 4'h3, 32'h0);
    tp(`OTS_TP_OTP_RD, 16'h07FF, 32'h0, 4'h1, rs);
    tp(`OTS_TP_STATE, 16'h0, 32'h0, 4'h5, 32'h0);
    tp(3'h7, 16'h0, 32'h0, 4'h2, 32'h0);
    brk;
    lvl({dbgPinOe_q, pinLevel}, 32'h2);
    dbgResume <= 1'b1;
    tick(1);
    dbgResume <= 1'b0;
    tick(2);
    lvl({dbgPinOe_q, pinLevel}, 32'h1);
    note(4'h8, 32'h0);
    pinPull;
    prog(`OTS_SEC_ADDR, SEC1, 4'h3);
    $display("test 1 finished");
    boot;
    lvl({bootFromOtp_q, redundRowsEn_q, 23'h0, swGpField_q}, 32'hC0000055);
    tp(`OTS_TP_USERCODE, 16'h0, 32'h0, 4'h1, {10'h2A5, 6'h0, REV});
    link(4'h7);
    rs = xs(rs);
    prog(16'h0000, rs, 4'h4);
    rd(16'h03FF, 32'h0);
    prog(16'h03FF, rs, 4'h3);
    rd(16'h03FF, rs);
    rd(16'h07FF, d0);
    tp(`OTS_TP_OTP_RD, 16'h03FF, 32'h0, 4'h2, 32'h0);
    tp(`OTS_TP_STATE, 16'h0, 32'h0, 4'h5, 32'h0);
    brk;
    lvl({dbgPinOe_q, pinLevel}, 32'h1);
    pinPull;
    prog(`OTS_SEC_ADDR, 32'h00001001, 4'h3);
    $display("test 2 finished");
    boot;
    prog(16'h05FF, rs, 4'h4);
    prog(`OTS_SEC_ADDR, 32'h2, 4'h4);
    rd(`OTS_SEC_ADDR, SEC1 | 32'h1001);
    rd(16'h05FF, 32'h0);
    tp(`OTS_TP_STATE, 16'h0, 32'h0, 4'h2, 32'h0);
    tp(`OTS_TP_OTP_RD, 16'h0000, 32'h0, 4'h2, 32'h0);
    tick(10);
    lvl(expQ.size(), 32'h0);
    $display("test 3 finished");
    summarize;
  end
endmodule

bind ots_top ots_props u_ots_props (.*);
